/* File: hw/hfa_pkg.sv */
// Constants for the host-side controller of a half-flash converter.
// Assumes a 50 MHz core clock; all pin times except ACC_CYC, which is given in cycles, are converted to cycles here.
package hfa_pkg;

	// ----------------------------------------------------------------
	// Clock and pin timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int T_WR_MIN_NS = 600;
	localparam int T_WR_TO_RD_NS = 600;
	localparam int T_RD_CONV_NS = 1600;
	localparam int T_DONE_WAIT_NS = 800;
	localparam int T_GAP_NS = 500;
	localparam int T_WAIT_MAX_NS = 4000;
	localparam logic [7:0] WR_CYC = 8'((T_WR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] WR_RD_CYC = 8'((T_WR_TO_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] RD_CONV_CYC = 8'((T_RD_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] DONE_CYC = 8'((T_DONE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] GAP_CYC = 8'((T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] WAIT_MAX_CYC = 8'(T_WAIT_MAX_NS / CLK_PERIOD_NS);
	localparam logic [7:0] ACC_CYC = 8'h10;

	// ----------------------------------------------------------------
	// Controller states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		HFA_IDLE = 3'h0,
		HFA_WR = 3'h1,
		HFA_WR_GAP = 3'h3,
		HFA_RD = 3'h2,
		HFA_RD_WAIT = 3'h6,
		HFA_GAP = 3'h7
	} hfa_state_t;

endpackage

/* File: hw/hfa_host.sv */
// Host controller that drives a half-flash converter through its pins.
// Assumes the converter's mode pin is strapped as given by i_mode_wr_rd
// and that its data, done and busy pins arrive asynchronously.
`timescale 1ns/10ps

module hfa_host
	import hfa_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// User request and result
	input wire logic i_mode_wr_rd,
	input wire logic i_early_read,
	input wire logic i_start,
	output logic o_ready,
	output logic o_valid,
	output logic [7:0] o_data,
	output logic o_over,
	output logic o_timeout,
	// Converter pins
	output logic o_chip_sel_n,
	output logic o_read_strobe_n,
	output logic o_conv_start_strobe_n,
	input wire logic i_conv_done_n,
	input wire logic i_busy_ack,
	input wire logic i_over_range,
	input wire logic [7:0] i_data
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [10:0] pin_meta;
	logic [10:0] pin_sync;

	always_ff @(posedge i_core_clk)
	begin
		pin_meta <= {i_conv_done_n, i_busy_ack, i_over_range, i_data};
		pin_sync <= pin_meta;
	end

	logic done_n_s;
	logic busy_s;
	logic over_s;
	logic [7:0] data_s;
	assign done_n_s = pin_sync[10];
	assign busy_s = pin_sync[9];
	assign over_s = pin_sync[8];
	assign data_s = pin_sync[7:0];

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	hfa_state_t state;
	hfa_state_t next_state;
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic early;
	logic next_early;
	logic valid;
	logic next_valid;
	logic [7:0] data;
	logic [7:0] next_data;
	logic over;
	logic next_over;
	logic tmo;
	logic next_tmo;
	logic cs_n;
	logic next_cs_n;
	logic rd_n;
	logic next_rd_n;
	logic wr_n;
	logic next_wr_n;

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_early = early;
		next_valid = 1'b0;
		next_data = data;
		next_over = over;
		next_tmo = tmo;
		next_cs_n = cs_n;
		next_rd_n = rd_n;
		next_wr_n = wr_n;
		case (state)
			HFA_IDLE:
			begin
				if (i_start)
				begin
					next_early = i_early_read;
					next_tmo = 1'b0;
					next_cnt = 8'h00;
					next_cs_n = 1'b0;
					if (i_mode_wr_rd)
					begin
						next_wr_n = 1'b0;
						next_state = HFA_WR;
					end
					else
					begin
						next_rd_n = 1'b0;
						next_state = HFA_RD_WAIT;
					end
				end
			end
			HFA_WR:
			begin
				next_cnt = cnt + 8'h01;
				if (cnt + 8'h01 >= WR_CYC)
				begin
					next_wr_n = 1'b1;
					next_cs_n = 1'b1;
					next_cnt = 8'h00;
					next_state = HFA_WR_GAP;
				end
			end
			HFA_WR_GAP:
			begin
				next_cnt = cnt + 8'h01;
				if (early && cnt + 8'h01 >= WR_RD_CYC)
				begin
					next_cs_n = 1'b0;
					next_rd_n = 1'b0;
					next_cnt = 8'h00;
					next_state = HFA_RD;
				end
				else if (!early && cnt + 8'h01 >= WR_RD_CYC
					&& (!done_n_s || cnt >= WAIT_MAX_CYC))
				begin
					next_tmo = done_n_s;
					next_cs_n = 1'b0;
					next_rd_n = 1'b0;
					next_cnt = 8'h00;
					next_state = HFA_RD;
				end
			end
			HFA_RD:
			begin
				next_cnt = cnt + 8'h01;
				if (cnt + 8'h01 >= ACC_CYC)
				begin
					next_data = data_s;
					next_over = over_s;
					next_valid = 1'b1;
					next_rd_n = 1'b1;
					next_cs_n = 1'b1;
					next_cnt = 8'h00;
					next_state = HFA_GAP;
				end
			end
			HFA_RD_WAIT:
			begin
				next_cnt = cnt + 8'h01;
				if ((cnt >= RD_CONV_CYC && !done_n_s && !busy_s)
					|| cnt >= WAIT_MAX_CYC)
				begin
					next_tmo = done_n_s;
					next_data = data_s;
					next_over = over_s;
					next_valid = 1'b1;
					next_rd_n = 1'b1;
					next_cs_n = 1'b1;
					next_cnt = 8'h00;
					next_state = HFA_GAP;
				end
			end
			HFA_GAP:
			begin
				next_cnt = cnt + 8'h01;
				if (cnt + 8'h01 >= GAP_CYC)
				begin
					next_cnt = 8'h00;
					next_state = HFA_IDLE;
				end
			end
			default:
			begin
				next_state = HFA_IDLE;
				next_cs_n = 1'b1;
				next_rd_n = 1'b1;
				next_wr_n = 1'b1;
			end
		endcase
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			state <= HFA_IDLE;
			cnt <= 8'h00;
			early <= 1'b0;
			valid <= 1'b0;
			data <= 8'h00;
			over <= 1'b0;
			tmo <= 1'b0;
			cs_n <= 1'b1;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			early <= next_early;
			valid <= next_valid;
			data <= next_data;
			over <= next_over;
			tmo <= next_tmo;
			cs_n <= next_cs_n;
			rd_n <= next_rd_n;
			wr_n <= next_wr_n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_ready = (state == HFA_IDLE);
	assign o_valid = valid;
	assign o_data = data;
	assign o_over = over;
	assign o_timeout = tmo;
	assign o_chip_sel_n = cs_n;
	assign o_read_strobe_n = rd_n;
	assign o_conv_start_strobe_n = wr_n;

endmodule // hfa_host

/* File: test/hfa_host_sva.sv */
// Checker for the host controller's converter pins.
// Bound to hfa_host; sees its ports only.
`timescale 1ns/10ps
module hfa_host_sva (
	// Clock, reset, request and valid
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_mode_wr_rd,
	input wire logic i_early_read,
	input wire logic o_valid,
	// Pins
	input wire logic o_chip_sel_n,
	input wire logic o_read_strobe_n,
	input wire logic o_conv_start_strobe_n
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	a_wr_width: assert property ($rose(o_conv_start_strobe_n) |->
		!$past(o_conv_start_strobe_n, 30)) else $error("write short");
	a_rd_after_wr: assert property ($fell(o_read_strobe_n) |->
		$past(o_conv_start_strobe_n, 30)) else $error("read early");
	a_early_time: assert property ($fell(o_read_strobe_n) &&
		i_mode_wr_rd && i_early_read |-> $past(o_conv_start_strobe_n, 30)
		&& !$past(o_conv_start_strobe_n, 31)) else $error("early read");
	a_rd_hold: assert property ($rose(o_read_strobe_n) &&
		i_mode_wr_rd |-> !$past(o_read_strobe_n, 16))
		else $error("read hold");
	a_ro_hold: assert property ($rose(o_read_strobe_n) &&
		!i_mode_wr_rd |-> !$past(o_read_strobe_n, 80))
		else $error("ro read");
	a_gap_next: assert property ($fell(o_chip_sel_n) |->
		$past(o_read_strobe_n, 25)) else $error("gap short");
	a_sel_strobe: assert property (o_chip_sel_n ==
		(o_read_strobe_n && o_conv_start_strobe_n)) else $error("select");
	a_valid_end: assert property (o_valid ==
		$rose(o_read_strobe_n)) else $error("valid");
endmodule // hfa_host_sva

/* File: test/hfa_dev_model.sv */
// Behavioural converter seen from its pins.
// Mode follows the strap input; slow stretches conversions.
`timescale 1ns/10ps
module hfa_dev_model (
	// Strap and test controls
	input wire logic i_mode,
	input wire logic i_slow,
	input wire logic [8:0] i_vin,
	// Host pins
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	output logic o_done_n,
	output logic o_busy,
	output logic o_over,
	output logic [7:0] o_data
);
	logic [8:0] res = '0;
	logic drv;
	initial o_done_n = 1'b1;
	initial o_busy = 1'b0;
	assign drv = !i_cs_n && !i_rd_n && (i_mode || !o_done_n);
	assign o_data = drv ? res[7:0] : ~res[7:0];
	assign o_over = res[8];
	always @(negedge i_wr_n) if (i_mode) res = i_vin;
	always @(posedge i_wr_n) if (i_mode)
	begin
		#(i_slow ? 3800 : 800);
		o_done_n = 1'b0;
	end
	always @(negedge i_rd_n) if (i_mode) o_done_n = 1'b0;
	always @(negedge i_rd_n) if (!i_mode)
	begin
		res = i_vin;
		o_busy = 1'b1;
		#(i_slow ? 4600 : 1600);
		o_busy = 1'b0;
		o_done_n = i_rd_n;
	end
	always @(posedge i_rd_n) #150 o_done_n = 1'b1;
endmodule // hfa_dev_model

/* File: test/hfa_host_tb.sv */
// Self-checking bench for the host controller.
// Runs it against the behavioural converter model.
`timescale 1ns/10ps
module hfa_host_tb;
	logic i_core_clk = 1'b0, i_sys_rst = 1'b1, mode = 1'b0, early = 1'b0;
	logic start = 1'b0, slow = 1'b0, ready, valid, over, tmo;
	logic cs_n, rd_n, wr_n, done_n, busy, ovr;
	logic [8:0] vin = '0;
	logic [7:0] data, pdata;
	int num_errors = 0, compares = 0;
	initial forever #10 i_core_clk = ~i_core_clk;
	hfa_host u_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_mode_wr_rd(mode), .i_early_read(early), .i_start(start),
		.o_ready(ready), .o_valid(valid), .o_data(data), .o_over(over),
		.o_timeout(tmo), .o_chip_sel_n(cs_n), .o_read_strobe_n(rd_n),
		.o_conv_start_strobe_n(wr_n), .i_conv_done_n(done_n),
		.i_busy_ack(busy), .i_over_range(ovr), .i_data(pdata));
	hfa_dev_model u_dev (.i_mode(mode), .i_slow(slow), .i_vin(vin),
		.i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .o_done_n(done_n),
		.o_busy(busy), .o_over(ovr), .o_data(pdata));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic conv(input logic m, e, s, input logic [8:0] v,
		input logic [7:0] d, input logic t, input int lo, hi);
		int n;
		int g;
		n = 0;
		g = 0;
		mode <= m;
		early <= e;
		slow <= s;
		vin <= v;
		start <= 1'b1;
		@(posedge i_core_clk);
		start <= 1'b0;
		do
		begin
			@(negedge i_core_clk);
			n++;
		end while (valid !== 1'b1 && n < 400);
		check(data, d);
		check(over, v[8]);
		check(tmo, t);
		check(32'(n >= lo && n <= hi), 1);
		do
		begin
			@(negedge i_core_clk);
			g++;
		end while (ready !== 1'b1 && g < 100);
		check(g, 25);
		@(posedge i_core_clk);
	endtask
	task automatic sc_read_only();
		conv(1'b0, 1'b0, 1'b0, 9'h1a5, 8'ha5, 1'b0, 82, 92);
	endtask
	task automatic sc_wr_early();
		conv(1'b1, 1'b1, 1'b0, 9'h03c, 8'h3c, 1'b0, 77, 77);
	endtask
	task automatic sc_wr_wait();
		conv(1'b1, 1'b0, 1'b0, 9'h1ff, 8'hff, 1'b0, 85, 100);
	endtask
	task automatic sc_wr_slow();
		conv(1'b1, 1'b0, 1'b1, 9'h081, 8'h81, 1'b0, 230, 250);
	endtask
	task automatic sc_ro_timeout();
		conv(1'b0, 1'b0, 1'b1, 9'h05a, 8'ha5, 1'b1, 195, 210);
	endtask
	initial
	begin
		repeat (2) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		repeat (30) @(posedge i_core_clk);
		sc_read_only();
		sc_wr_early();
		sc_wr_wait();
		sc_wr_slow();
		sc_ro_timeout();
		conclude();
	end
	initial
	begin
		#60000;
		num_errors++;
		conclude();
	end
endmodule // hfa_host_tb
bind hfa_host hfa_host_sva u_sva (.i_core_clk(i_core_clk),
	.i_sys_rst(i_sys_rst), .i_mode_wr_rd(i_mode_wr_rd),
	.i_early_read(i_early_read), .o_valid(o_valid),
	.o_chip_sel_n(o_chip_sel_n), .o_read_strobe_n(o_read_strobe_n),
	.o_conv_start_strobe_n(o_conv_start_strobe_n));
